// ==== cie_unit.sv ====
// Interrupt flag and enable unit: enables, sticky flags, summaries and request.
//
// Contract
// - Enable bits read/write, zero after reset.
// - Hardware sets sticky flags; only host clears.
// - System error sets flag at bit 12.
// - Bit 11 shows any receive FIFO overflow except FIFO 0.
// - Bit 10 transmit attempt flag is read-only.
// - Bits 9 and 8 CRC, ECC read-only.
// - Bit 4 shows transmit event FIFO pending.
// - Mode field change sets bit 3.
// - Time base wrap sets bit 2.
// - Bit 1 shows any receive FIFO pending except FIFO 0.
// - Bit 0 shows any transmit FIFO pending.
// - Receive summary bit ORs enabled FIFO flags.
// - Summary self-clears; host writes ignored.
// - Overflow summary, one read-only bit per FIFO.
// - Reserved bits and the FIFO 0 bits of the receive and overflow summaries read zero.
// - Code names highest-numbered pending source.
// - Transmit summary ORs enabled flags, bit 0 queue.
`timescale 1ns/10ps
module cie_unit
    import cie_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] reg_idx,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic bad_message_evt,
    input wire logic wake_evt,
    input wire logic bus_error_evt,
    input wire logic serr_mab_evt,
    input wire logic serr_addr_evt,
    input wire logic [MODE_W-1:0] operating_mode_field,
    input wire logic [31:0] timebase_counter,
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] rx_fifo_flags,
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] rx_fifo_enables,
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] tx_fifo_flags,
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] tx_fifo_enables,
    input wire logic [NUM_FIFO-1:0] rx_ovf_pending,
    input wire logic [NUM_FIFO-1:0] tx_attempt_pending,
    input wire logic tx_event_fifo_pending,
    input wire logic serial_crc_pending,
    input wire logic memory_ecc_pending,
    input wire logic [4:0] filter_hit,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Summaries of the per-FIFO conditions.

    cie_state_t s_q;
    cie_state_t s_d;
    logic [31:0] rx_raw;
    logic [31:0] tx_sum;
    logic [31:0] rx_sum;
    logic [31:0] ov_sum;
    logic [31:0] at_sum;
    logic [31:0] int_view;
    logic [31:0] code_word;

    cie_summary u_rx_sum (
        .flags(rx_fifo_flags),
        .enables(rx_fifo_enables),
        .pending(rx_raw)
    );

    cie_summary u_tx_sum (
        .flags(tx_fifo_flags),
        .enables(tx_fifo_enables),
        .pending(tx_sum)
    );

    // Summaries are pure wires of the FIFO state, so they drop on their own.
    assign rx_sum = rx_raw & FIFO_SUM_MASK;
    // Overflow bits are cleared only at the FIFO; nothing here can clear them.
    assign ov_sum = rx_ovf_pending & FIFO_SUM_MASK;
    assign at_sum = tx_attempt_pending;

    ////////////////////////////////////////////////////////////////////////////////
    // Read view of the enable and flag register.

    always_comb begin
        int_view = s_q.int_reg & (EN_MASK | STICKY_MASK);
        int_view[F_RXOV] = |ov_sum;
        int_view[F_TXAT] = |at_sum;
        int_view[F_CRC] = serial_crc_pending;
        int_view[F_ECC] = memory_ecc_pending;
        int_view[F_TEF] = tx_event_fifo_pending;
        int_view[F_RX] = |rx_sum;
        int_view[F_TX] = |tx_sum;
    end

    cie_code_enc u_code (
        .int_view(int_view),
        .serr_mab(s_q.serr_mab),
        .rx_sum(rx_sum),
        .tx_sum(tx_sum),
        .filter_hit(filter_hit),
        .code_word(code_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [31:0] lanes;
        logic [31:0] clr;
        logic [31:0] set;
        logic wr_int;
        lanes = cie_lane_mask(reg_be);
        wr_int = reg_wr && (reg_idx == IDX_INT);
        clr = '0;
        set = '0;
        s_d = s_q;

        // Enables take written data in their enabled lanes.
        if (wr_int) begin
            s_d.int_reg = (s_q.int_reg & ~(EN_MASK & lanes))
                        | (reg_wdata & EN_MASK & lanes);
        end

        // Writing zero to a sticky flag clears it; writing one leaves it alone.
        if (wr_int) begin
            clr = ~reg_wdata & STICKY_MASK & lanes;
        end
        s_d.int_reg = s_d.int_reg & ~clr;

        // Hardware events; set is applied after clear so a same-cycle event wins.
        set[F_BADMSG] = bad_message_evt;
        set[F_WAKE] = wake_evt;
        set[F_BUSERR] = bus_error_evt;
        set[F_SYSERR] = serr_mab_evt | serr_addr_evt;
        // The first cycle after reset only learns the mode, so reset is no change.
        set[F_MODE] = s_q.mode_seen
                    && (operating_mode_field != s_q.mode_prev);
        set[F_TBC] = s_q.tbc_at_max && (timebase_counter == '0);
        s_d.int_reg = s_d.int_reg | set;

        if (serr_mab_evt) begin
            s_d.serr_mab = 1'b1;
        end else if (serr_addr_evt) begin
            s_d.serr_mab = 1'b0;
        end
        s_d.mode_prev = operating_mode_field;
        s_d.mode_seen = 1'b1;
        s_d.tbc_at_max = (timebase_counter == TBC_MAX);

        // Read data is captured on the read strobe and held until the next read.
        if (reg_rd) begin
            unique case (reg_idx)
                IDX_INT: s_d.rdata = int_view;
                IDX_RXSUM: s_d.rdata = rx_sum;
                IDX_OVSUM: s_d.rdata = ov_sum;
                IDX_TXSUM: s_d.rdata = tx_sum;
                IDX_ATSUM: s_d.rdata = at_sum;
                IDX_CODE: s_d.rdata = code_word;
                default: s_d.rdata = '0;
            endcase
        end

        // Each flag lines up with its enable EN_OFS bits higher.
        s_d.irq = |(int_view[15:0] & s_q.int_reg[31:16]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{int_reg: INT_RESET, serr_mab: 1'b0, mode_prev: '0, mode_seen: 1'b0,
                     tbc_at_max: 1'b0, rdata: '0, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq = s_q.irq;

endmodule : cie_unit

// ==== cie_pkg.sv ====
// Constants, types and helpers shared by the interrupt flag and enable unit.
package cie_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes.
    localparam int unsigned NUM_FIFO = 32;
    localparam int unsigned FLAGS_PER_FIFO = 3;
    localparam int unsigned MODE_W = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Register index values on reg_idx.
    localparam logic [2:0] IDX_INT = 3'h0;
    localparam logic [2:0] IDX_RXSUM = 3'h1;
    localparam logic [2:0] IDX_OVSUM = 3'h2;
    localparam logic [2:0] IDX_TXSUM = 3'h3;
    localparam logic [2:0] IDX_ATSUM = 3'h4;
    localparam logic [2:0] IDX_CODE = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // Flag positions in the enable and flag register; each enable sits EN_OFS above.
    localparam int unsigned EN_OFS = 16;
    localparam int unsigned F_BADMSG = 15;
    localparam int unsigned F_WAKE = 14;
    localparam int unsigned F_BUSERR = 13;
    localparam int unsigned F_SYSERR = 12;
    localparam int unsigned F_RXOV = 11;
    localparam int unsigned F_TXAT = 10;
    localparam int unsigned F_CRC = 9;
    localparam int unsigned F_ECC = 8;
    localparam int unsigned F_TEF = 4;
    localparam int unsigned F_MODE = 3;
    localparam int unsigned F_TBC = 2;
    localparam int unsigned F_RX = 1;
    localparam int unsigned F_TX = 0;
    localparam logic [31:0] EN_MASK = 32'hff1f0000;
    localparam logic [31:0] STICKY_MASK = 32'h0000f00c;
    localparam logic [31:0] INT_RESET = 32'h00000000;
    localparam logic [31:0] FIFO_SUM_MASK = 32'hfffffffe;
    localparam logic [31:0] TBC_MAX = 32'hffffffff;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt code register layout and codes.
    localparam int unsigned RXCODE_LSB = 24;
    localparam int unsigned TXCODE_LSB = 16;
    localparam int unsigned FILHIT_LSB = 8;
    localparam int unsigned ICODE_LSB = 0;
    localparam logic [6:0] C_NONE = 7'h40;
    localparam logic [6:0] C_BUSERR = 7'h41;
    localparam logic [6:0] C_WAKE = 7'h42;
    localparam logic [6:0] C_RXOV = 7'h43;
    localparam logic [6:0] C_ADDR = 7'h44;
    localparam logic [6:0] C_MAB = 7'h45;
    localparam logic [6:0] C_TBC = 7'h46;
    localparam logic [6:0] C_MODE = 7'h47;
    localparam logic [6:0] C_BADMSG = 7'h48;
    localparam logic [6:0] C_TEF = 7'h49;
    localparam logic [6:0] C_TXAT = 7'h4a;
    localparam logic [31:0] CODE_RESET = 32'h40400040;

    typedef struct packed {
        logic [31:0] int_reg;
        logic serr_mab;
        logic [MODE_W-1:0] mode_prev;
        logic mode_seen;
        logic tbc_at_max;
        logic [31:0] rdata;
        logic irq;
    } cie_state_t;

    // Returns {valid, index of the highest set bit}.
    function automatic logic [5:0] cie_top_index(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : cie_top_index

    // Expands four byte enables to a 32-bit lane mask.
    function automatic logic [31:0] cie_lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : cie_lane_mask

endpackage : cie_pkg

// ==== cie_summary.sv ====
// Per-FIFO OR of enabled interrupt flags into one pending bit per FIFO.
`timescale 1ns/10ps
module cie_summary
    import cie_pkg::*;
(
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] flags,
    input wire logic [NUM_FIFO*FLAGS_PER_FIFO-1:0] enables,
    output logic [NUM_FIFO-1:0] pending
);

    always_comb begin
        pending = '0;
        for (int f = 0; f < NUM_FIFO; f++) begin
            pending[f] = |(flags[f*FLAGS_PER_FIFO +: FLAGS_PER_FIFO]
                        & enables[f*FLAGS_PER_FIFO +: FLAGS_PER_FIFO]);
        end
    end

endmodule : cie_summary

// ==== cie_code_enc.sv ====
// Interrupt code encoder: picks the highest-numbered pending source.
`timescale 1ns/10ps
module cie_code_enc
    import cie_pkg::*;
(
    input wire logic [31:0] int_view,
    input wire logic serr_mab,
    input wire logic [31:0] rx_sum,
    input wire logic [31:0] tx_sum,
    input wire logic [4:0] filter_hit,
    output logic [31:0] code_word
);

    logic [15:0] act;
    logic [5:0] rx_top;
    logic [5:0] tx_top;
    logic [5:0] any_top;
    logic [6:0] rxcode;
    logic [6:0] txcode;
    logic [6:0] icode;

    always_comb begin
        act = int_view[15:0] & int_view[31:16];
        rx_top = cie_top_index(rx_sum & FIFO_SUM_MASK);
        tx_top = cie_top_index(tx_sum);
        any_top = cie_top_index((rx_sum & FIFO_SUM_MASK) | tx_sum);
        rxcode = rx_top[5] ? {2'b00, rx_top[4:0]} : C_NONE;
        txcode = tx_top[5] ? {2'b00, tx_top[4:0]} : C_NONE;
        // A system error carries one flag, so the last cause seen picks its code; MAB wins when both come in one cycle.
        if (act[F_TXAT]) begin
            icode = C_TXAT;
        end else if (act[F_TEF]) begin
            icode = C_TEF;
        end else if (act[F_BADMSG]) begin
            icode = C_BADMSG;
        end else if (act[F_MODE]) begin
            icode = C_MODE;
        end else if (act[F_TBC]) begin
            icode = C_TBC;
        end else if (act[F_SYSERR]) begin
            icode = serr_mab ? C_MAB : C_ADDR;
        end else if (act[F_RXOV]) begin
            icode = C_RXOV;
        end else if (act[F_WAKE]) begin
            icode = C_WAKE;
        end else if (act[F_BUSERR]) begin
            icode = C_BUSERR;
        end else if (any_top[5]) begin
            icode = {2'b00, any_top[4:0]};
        end else begin
            icode = C_NONE;
        end
        code_word = '0;
        code_word[RXCODE_LSB +: 7] = rxcode;
        code_word[TXCODE_LSB +: 7] = txcode;
        code_word[FILHIT_LSB +: 5] = filter_hit;
        code_word[ICODE_LSB +: 7] = icode;
    end

endmodule : cie_code_enc

// ==== cie_unit_chk_asserts.sv ====
// Port checker for the interrupt flag and enable unit.
`timescale 1ns/10ps
module cie_unit_chk
    import cie_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] reg_idx,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic bad_message_evt,
    input wire logic serr_addr_evt,
    input wire logic [31:0] timebase_counter,
    input wire logic [95:0] rx_fifo_flags,
    input wire logic [95:0] rx_fifo_enables,
    input wire logic [95:0] tx_fifo_flags,
    input wire logic [95:0] tx_fifo_enables,
    input wire logic [31:0] rx_ovf_pending,
    input wire logic [31:0] tx_attempt_pending,
    input wire logic tx_event_fifo_pending,
    input wire logic serial_crc_pending,
    input wire logic memory_ecc_pending
);
    ////////////////////////////////////////////////////////////////////////////////
    // Views are registered so a read is judged against the inputs of its own edge.
    logic [31:0] rx_q, ov_q, tx_q;
    logic [6:0] lv_q;
    function automatic logic [31:0] fold(input logic [95:0] f, input logic [95:0] e);
        for (int i = 0; i < 32; i++) begin
            fold[i] = |(f[3*i+:3] & e[3*i+:3]);
        end
    endfunction : fold
    always_ff @(posedge clk) begin
        rx_q <= fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK;
        ov_q <= rx_ovf_pending & FIFO_SUM_MASK;
        tx_q <= fold(tx_fifo_flags, tx_fifo_enables);
        lv_q <= {|(rx_ovf_pending & FIFO_SUM_MASK), |tx_attempt_pending, serial_crc_pending,
            memory_ecc_pending, tx_event_fifo_pending,
            |(fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK),
            |fold(tx_fifo_flags, tx_fifo_enables)};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rd(logic [2:0] i);
        reg_rd && reg_idx == i;
    endsequence
    sequence s_evt_rd(logic e);
        e ##[1:3] s_rd(IDX_INT);
    endsequence
    property p_rx; s_rd(IDX_RXSUM) |=> reg_rdata == rx_q; endproperty
    a_rx: assert property (p_rx) else $error("receive summary wrong");
    property p_ov; s_rd(IDX_OVSUM) |=> reg_rdata == ov_q; endproperty
    a_ov: assert property (p_ov) else $error("overflow summary wrong");
    property p_tx; s_rd(IDX_TXSUM) |=> reg_rdata == tx_q; endproperty
    a_tx: assert property (p_tx) else $error("transmit summary wrong");
    property p_lv; s_rd(IDX_INT) |=> {reg_rdata[11:8], reg_rdata[4], reg_rdata[1:0]} == lv_q;
    endproperty
    a_lv: assert property (p_lv) else $error("live flags wrong");
    property p_rsv; s_rd(IDX_INT) |=> reg_rdata[23:21] == 3'h0 && reg_rdata[7:5] == 3'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_bad; s_evt_rd(bad_message_evt) |=> reg_rdata[F_BADMSG]; endproperty
    a_bad: assert property (p_bad) else $error("event flag not set");
    property p_serr; s_evt_rd(serr_addr_evt) |=> reg_rdata[F_SYSERR]; endproperty
    a_serr: assert property (p_serr) else $error("system error flag not set");
    property p_tbc;
        timebase_counter == TBC_MAX ##1 timebase_counter == 32'h0 ##[1:3] s_rd(IDX_INT)
        |=> reg_rdata[F_TBC];
    endproperty
    a_tbc: assert property (p_tbc) else $error("wrap flag not set");
    property p_irq; s_rd(IDX_INT) |=> irq == |(reg_rdata[31:16] & reg_rdata[15:0]); endproperty
    a_irq: assert property (p_irq) else $error("request disagrees with flags");
endmodule : cie_unit_chk
bind cie_unit cie_unit_chk u_chk (.clk, .srst, .reg_idx, .reg_rd, .reg_rdata, .irq,
    .bad_message_evt, .serr_addr_evt, .timebase_counter, .rx_fifo_flags, .rx_fifo_enables,
    .tx_fifo_flags, .tx_fifo_enables, .rx_ovf_pending, .tx_attempt_pending,
    .tx_event_fifo_pending, .serial_crc_pending, .memory_ecc_pending);

// ==== cie_host_model.sv ====
// Host side model driving the register port one word at a time.
`timescale 1ns/10ps
module cie_host_model (
    input wire logic clk,
    output logic [2:0] reg_idx,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_be,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    initial begin
        {reg_idx, reg_wr, reg_rd, reg_be, reg_wdata} = '0;
    end
    // Sticky flags are only ever cleared from here, by writing zero.
    task automatic wr(input logic [2:0] i, input logic [3:0] b, input logic [31:0] v);
        @(posedge clk);
        reg_idx <= i;
        reg_be <= b;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [2:0] i, output logic [31:0] v);
        @(posedge clk);
        reg_idx <= i;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
endmodule : cie_host_model

// ==== tb.sv ====
// Self-checking bench for the interrupt flag and enable unit.
`timescale 1ns/10ps
module tb;
    import cie_pkg::*;
    logic clk, srst, reg_wr, reg_rd, irq;
    logic [2:0] reg_idx, operating_mode_field;
    logic [3:0] reg_be;
    logic [4:0] filter_hit;
    logic [31:0] reg_wdata, reg_rdata, timebase_counter, rx_ovf_pending, tx_attempt_pending, d;
    logic bad_message_evt, wake_evt, bus_error_evt, serr_mab_evt, serr_addr_evt;
    logic tx_event_fifo_pending, serial_crc_pending, memory_ecc_pending;
    logic [95:0] rx_fifo_flags, rx_fifo_enables, tx_fifo_flags, tx_fifo_enables;
    int errors, checked;
    ////////////////////////////////////////////////////////////////////////////////
    cie_host_model host (.clk, .reg_idx, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata);
    cie_unit DUT (.clk, .srst, .reg_idx, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata,
        .bad_message_evt, .wake_evt, .bus_error_evt, .serr_mab_evt, .serr_addr_evt,
        .operating_mode_field, .timebase_counter, .rx_fifo_flags, .rx_fifo_enables,
        .tx_fifo_flags, .tx_fifo_enables, .rx_ovf_pending, .tx_attempt_pending,
        .tx_event_fifo_pending, .serial_crc_pending, .memory_ecc_pending, .filter_hit, .irq);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] fold(input logic [95:0] f, input logic [95:0] e);
        for (int i = 0; i < 32; i++) begin
            fold[i] = |(f[3*i+:3] & e[3*i+:3]);
        end
    endfunction : fold
    // Highest set bit as a FIFO code, or the no-interrupt code when none is set.
    function automatic logic [6:0] top_code(input logic [31:0] v);
        top_code = C_NONE;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                top_code = 7'(i);
            end
        end
    endfunction : top_code
    // The first two passes give the all-ones and all-zero corners.
    function automatic logic [95:0] pick(input int n);
        if (n < 2) begin
            return (n == 0) ? '1 : '0;
        end
        return {$urandom, $urandom, $urandom};
    endfunction : pick
    task automatic report_and_stop();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait, since a stuck request must not hang the run.
    task automatic wait_irq(input logic v);
        for (int k = 0; k < 8 && irq !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk({31'h0, irq}, {31'h0, v});
        if (irq !== v) begin
            report_and_stop();
        end
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checked = 0;
        srst = 1'b1;
        {bad_message_evt, wake_evt, bus_error_evt, serr_mab_evt, serr_addr_evt} = '0;
        {operating_mode_field, timebase_counter, rx_ovf_pending, tx_attempt_pending} = '0;
        {tx_event_fifo_pending, serial_crc_pending, memory_ecc_pending, filter_hit} = '0;
        {rx_fifo_flags, rx_fifo_enables, tx_fifo_flags, tx_fifo_enables} = '0;
        void'($urandom(60));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        host.rd(IDX_INT, d); chk(d, INT_RESET);
        host.rd(IDX_CODE, d); chk(d, CODE_RESET);
        host.rd(3'h7, d); chk(d, 32'h0);
        host.wr(IDX_INT, 4'hf, 32'hffffffff);
        host.rd(IDX_INT, d); chk(d, EN_MASK);
        $display("test reset and enables done");
        @(posedge clk);
        {bad_message_evt, wake_evt, bus_error_evt, serr_addr_evt} <= 4'hf;
        @(posedge clk);
        {bad_message_evt, wake_evt, bus_error_evt, serr_addr_evt} <= 4'h0;
        host.rd(IDX_INT, d); chk(d, EN_MASK | 32'h0000f000);
        host.rd(IDX_CODE, d); chk(d, {16'h4040, 9'h0, C_BADMSG});
        wait_irq(1'b1);
        host.wr(IDX_INT, 4'h2, 32'h0000ffff);
        host.wr(IDX_INT, 4'h1, 32'h0);
        host.rd(IDX_INT, d); chk(d, EN_MASK | 32'h0000f000);
        host.wr(IDX_INT, 4'h2, 32'h0);
        host.rd(IDX_INT, d); chk(d, EN_MASK);
        wait_irq(1'b0);
        @(posedge clk);
        serr_mab_evt <= 1'b1;
        operating_mode_field <= 3'h5;
        timebase_counter <= TBC_MAX;
        @(posedge clk);
        serr_mab_evt <= 1'b0;
        timebase_counter <= 32'h0;
        host.rd(IDX_INT, d); chk(d, EN_MASK | 32'h0000100c);
        host.rd(IDX_CODE, d); chk(d, {16'h4040, 9'h0, C_MODE});
        host.wr(IDX_INT, 4'h1, 32'h0);
        host.rd(IDX_CODE, d); chk(d, {16'h4040, 9'h0, C_MAB});
        host.wr(IDX_INT, 4'hf, 32'h0);
        host.rd(IDX_INT, d); chk(d, 32'h0);
        $display("test sticky flags done");
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            rx_fifo_flags <= pick(n) & pick(n);
            rx_fifo_enables <= pick(n);
            tx_fifo_flags <= pick(n) & pick(n);
            tx_fifo_enables <= pick(n);
            rx_ovf_pending <= 32'(pick(n) & pick(n));
            tx_attempt_pending <= 32'(pick(n) & pick(n) & pick(n));
            {tx_event_fifo_pending, serial_crc_pending, memory_ecc_pending} <= 3'(pick(n));
            filter_hit <= 5'(pick(n));
            host.wr(IDX_RXSUM, 4'hf, 32'hffffffff);
            host.rd(IDX_RXSUM, d);
            chk(d, fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK);
            host.rd(IDX_OVSUM, d); chk(d, rx_ovf_pending & FIFO_SUM_MASK);
            host.rd(IDX_TXSUM, d); chk(d, fold(tx_fifo_flags, tx_fifo_enables));
            host.rd(IDX_INT, d);
            chk(d, {20'h0, |(rx_ovf_pending & FIFO_SUM_MASK), |tx_attempt_pending,
                serial_crc_pending, memory_ecc_pending, 3'h0, tx_event_fifo_pending, 2'h0,
                |(fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK),
                |fold(tx_fifo_flags, tx_fifo_enables)});
            host.rd(IDX_ATSUM, d); chk(d, tx_attempt_pending);
            host.rd(IDX_CODE, d);
            chk(d, {1'b0, top_code(fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK), 1'b0,
                top_code(fold(tx_fifo_flags, tx_fifo_enables)), 3'h0, filter_hit, 1'b0,
                top_code((fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK)
                | fold(tx_fifo_flags, tx_fifo_enables))});
        end
        host.wr(IDX_INT, 4'h4, 32'h00020000);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, |(fold(rx_fifo_flags, rx_fifo_enables) & FIFO_SUM_MASK)});
        $display("test random summaries done");
        report_and_stop();
    end
endmodule : tb
